/* logic/cic_pkg.sv */
/*
 * cic_pkg: constants and types shared by the charger input/control register block.
 * Assumes an 8-bit register file reached through a two-wire serial target port.
 */
package cic_pkg;

   // ****************************************
   // serial target port
   // ****************************************
   localparam logic [6:0] I2C_TARGET_ADDR = 7'h6a;
   localparam logic [7:0] NUM_REGS = 8'h02;
   localparam logic [7:0] UNMAPPED_RD = 8'hff;
   // synchroniser reset: psel=0, ce_n=1, sda=1, scl=1
   localparam logic [3:0] SYNC_RST = 4'h7;

   // ****************************************
   // register offsets and reset values
   // ****************************************
   localparam logic [7:0] INLIM_OFS = 8'h00;
   localparam logic [7:0] CTRL0_OFS = 8'h01;
   localparam logic [7:0] INLIM_RST = 8'h17;
   localparam logic [7:0] CTRL0_RST = 8'h1a;
   // fields that also return to default on watchdog expiry
   localparam logic [7:0] WD_MASK0 = 8'h80;
   localparam logic [7:0] WD_MASK1 = 8'h50;

   // ****************************************
   // field positions
   // ****************************************
   localparam int HIZ_BIT = 7;
   localparam int TSOVR_BIT = 6;
   localparam int RSNS_BIT = 5;
   localparam int ILIM_MSB = 4;
   localparam int PFM_BIT = 7;
   localparam int KICK_BIT = 6;
   localparam int CHGEN_BIT = 4;
   localparam int SYSMIN_MSB = 3;
   localparam int SYSMIN_LSB = 1;

   // ****************************************
   // input current limit coding
   // ****************************************
   localparam logic [4:0] ILIM_PSEL_HIGH = 5'h04;
   localparam logic [4:0] ILIM_PSEL_LOW = 5'h17;
   localparam logic [11:0] ILIM_OFFSET_MA = 12'h064;
   localparam logic [11:0] ILIM_STEP_MA = 12'h064;

   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_RDATA,
                             ST_RACK} cic_i2c_t;

   // limit code to milliamps: offset plus binary weights
   function automatic logic [11:0] ilim_ma(input logic [4:0] code);
      ilim_ma = ILIM_OFFSET_MA + ILIM_STEP_MA * {7'h00, code};
   endfunction : ilim_ma

   // system minimum voltage code to millivolts
   function automatic logic [11:0] sysmin_mv(input logic [2:0] code);
      case (code)
         3'h0: sysmin_mv = 12'ha28;
         3'h1: sysmin_mv = 12'haf0;
         3'h2: sysmin_mv = 12'hbb8;
         3'h3: sysmin_mv = 12'hc80;
         3'h4: sysmin_mv = 12'hd48;
         3'h5: sysmin_mv = 12'hdac;
         3'h6: sysmin_mv = 12'he10;
         default: sysmin_mv = 12'he74;
      endcase
   endfunction : sysmin_mv

endpackage : cic_pkg

/* logic/cic_sync.sv */
/*
 * cic_sync: three-flop synchroniser with agreement filter for pin inputs.
 * Assumes inputs are asynchronous to clock; output changes once stages 2 and 3 agree.
 */
`timescale 1ns/1ps
module cic_sync import cic_pkg::*; #(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } cic_sync_t;

   cic_sync_t s_ff;
   cic_sync_t nxt_s;

   // ****************************************
   // shift and filter
   // ****************************************
   // first stage feeds only the second; a glitch shorter than a cycle never reaches q
   always_comb begin
      nxt_s = s_ff;
      nxt_s.s1 = din;
      nxt_s.s2 = s_ff.s1;
      nxt_s.s3 = s_ff.s2;
      for (int i = 0; i < W; i++) begin
         if (s_ff.s2[i] == s_ff.s3[i]) begin
            nxt_s.q[i] = s_ff.s3[i];
         end
      end
   end

   // register the state, reset to idle pin levels
   always_ff @(posedge clock) begin
      if (!rstn) begin
         s_ff <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign dout = s_ff.q;

endmodule : cic_sync

/* logic/cic_regs.sv */
/*
 * cic_regs: input-limit and charger-control registers behind a serial target port.
 * Assumes the host drives the serial clock and that analog loops read the field outputs.
 */
// What this block does
// - An 8-bit read/write register at offset 0x00 holds input controls, reset 0x17.
// - An 8-bit read/write register at offset 0x01 holds charger controls, reset 0x1a.
// - Bit 7 of the input register enables the high-impedance state in buck mode.
// - Bit 6 set makes the thermistor always good for charging and reports fault 000.
// - Bit 5 picks regulation through the battery pin (1) or remote sense pin (0).
// - Bits 4:0 are the input limit: 100 mA offset plus 100 mA per code step.
// - The input limit resets to code 10111, which is 2400 mA.
// - Source detection loads 500 mA when the select pin is high, 2.4 A when low.
// - High-impedance, kick and charge enable also return to default on watchdog expiry.
// - Bit 7 of the control register disables pulse-frequency mode when set.
// - Writing 1 to bit 6 restarts the watchdog and the bit then clears itself.
// - Charging needs chip enable low, charge enable bit set and nonzero current.
// - Bits 3:1 select system minimum voltage from 2.6 V to 3.7 V, default 3.5 V.
// - The registers are reached as serial target at 7-bit address 0x6a.
// - Any register write moves the charger from default mode to host mode.
`timescale 1ns/1ps
module cic_regs import cic_pkg::*; (
   input wire logic clock,
   input wire logic rstn,
   input wire logic scl_pin,
   input wire logic sda_pin_i,
   output logic sda_pin_o,
   output logic sda_pin_oe,
   input wire logic ce_n_pin,
   input wire logic psel_pin,
   input wire logic reg_reset,
   input wire logic wdog_expire,
   input wire logic src_detect_done,
   input wire logic ts_good,
   input wire logic [2:0] thermistor_fault_code_raw,
   input wire logic ichg_nonzero,
   output logic high_impedance_enable,
   output logic temp_sense_override,
   output logic remote_sense_disable,
   output logic [4:0] input_current_limit,
   output logic [11:0] input_limit_ma,
   output logic pulse_freq_mode_disable,
   output logic watchdog_restart,
   output logic charge_enable_bit,
   output logic [2:0] system_min_voltage,
   output logic [11:0] system_min_voltage_mv,
   output logic [2:0] thermistor_fault_code,
   output logic charge_active,
   output logic host_mode
);

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      cic_i2c_t st;
      cic_i2c_t ack_nxt;
      logic [7:0] sh;
      logic [2:0] cnt;
      logic got;
      logic [7:0] ptr;
      logic oe;
      logic scl_q;
      logic sda_q;
      logic [7:0] reg0;
      logic [7:0] reg1;
      logic host;
      logic chg;
      logic [2:0] ntc;
   } cic_state_t;

   cic_state_t s_ff;
   cic_state_t nxt_s;
   logic [3:0] pins_f;
   logic scl_f;
   logic sda_f;
   logic ce_n_f;
   logic psel_f;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic wr_en;

   // read data; offsets past the map read as all ones
   function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic [7:0] r0,
                                          input logic [7:0] r1);
      if (p == INLIM_OFS) begin
         rd_byte = r0;
      end else if (p == CTRL0_OFS) begin
         rd_byte = r1;
      end else begin
         rd_byte = UNMAPPED_RD;
      end
   endfunction : rd_byte

   // ****************************************
   // pin synchronisers
   // ****************************************
   cic_sync #(.W(4), .RST_VAL(SYNC_RST)) u_sync (
      .clock(clock),
      .rstn(rstn),
      .din({psel_pin, ce_n_pin, sda_pin_i, scl_pin}),
      .dout(pins_f)
   );

   assign scl_f = pins_f[0];
   assign sda_f = pins_f[1];
   assign ce_n_f = pins_f[2];
   assign psel_f = pins_f[3];

   // bus events seen on the filtered lines
   assign rise = scl_f & ~s_ff.scl_q;
   assign fall = ~scl_f & s_ff.scl_q;
   assign start = scl_f & s_ff.scl_q & s_ff.sda_q & ~sda_f;
   assign stop = scl_f & s_ff.scl_q & ~s_ff.sda_q & sda_f;

   // ****************************************
   // next-state logic
   // ****************************************
   always_comb begin
      nxt_s = s_ff;
      wr_en = 1'b0;
      nxt_s.scl_q = scl_f;
      nxt_s.sda_q = sda_f;
      // kick lives one cycle: that cycle is the restart pulse
      if (s_ff.reg1[KICK_BIT]) begin
         nxt_s.reg1[KICK_BIT] = 1'b0;
      end
      case (s_ff.st)
         ST_ADDR, ST_PTR, ST_WDATA: begin
            if (rise) begin
               nxt_s.sh = {s_ff.sh[6:0], sda_f};
               nxt_s.cnt = s_ff.cnt + 3'h1;
               nxt_s.got = (s_ff.cnt == 3'h7);
            end
            // a byte is decided on the falling edge after its eighth bit
            if (fall && s_ff.got) begin
               nxt_s.got = 1'b0;
               nxt_s.st = ST_IDLE;
               case (s_ff.st)
                  ST_ADDR: begin
                     if (s_ff.sh[7:1] == I2C_TARGET_ADDR) begin
                        nxt_s.ack_nxt = s_ff.sh[0] ? ST_RDATA : ST_PTR;
                        nxt_s.st = ST_ACK;
                        nxt_s.oe = 1'b1;
                     end
                  end
                  ST_PTR: begin
                     // undefined offsets are not acknowledged
                     if (s_ff.sh < NUM_REGS) begin
                        nxt_s.ptr = s_ff.sh;
                        nxt_s.ack_nxt = ST_WDATA;
                        nxt_s.st = ST_ACK;
                        nxt_s.oe = 1'b1;
                     end
                  end
                  default: begin
                     if (s_ff.ptr < NUM_REGS) begin
                        wr_en = 1'b1;
                        nxt_s.ptr = s_ff.ptr + 8'h01;
                        nxt_s.ack_nxt = ST_WDATA;
                        nxt_s.st = ST_ACK;
                        nxt_s.oe = 1'b1;
                     end
                  end
               endcase
            end
         end
         ST_ACK: begin
            if (fall) begin
               nxt_s.st = s_ff.ack_nxt;
               nxt_s.cnt = 3'h0;
               nxt_s.oe = 1'b0;
               if (s_ff.ack_nxt == ST_RDATA) begin
                  nxt_s.sh = rd_byte(s_ff.ptr, s_ff.reg0, s_ff.reg1);
                  nxt_s.oe = ~nxt_s.sh[7];
               end
            end
         end
         ST_RDATA: begin
            if (fall) begin
               if (s_ff.cnt == 3'h7) begin
                  nxt_s.st = ST_RACK;
                  nxt_s.oe = 1'b0;
                  nxt_s.ptr = s_ff.ptr + 8'h01;
               end else begin
                  nxt_s.cnt = s_ff.cnt + 3'h1;
                  nxt_s.sh = {s_ff.sh[6:0], 1'b0};
                  nxt_s.oe = ~s_ff.sh[6];
               end
            end
         end
         ST_RACK: begin
            if (rise) begin
               nxt_s.got = ~sda_f;
            end
            // host ack continues the burst, nack ends it
            if (fall) begin
               nxt_s.got = 1'b0;
               if (s_ff.got) begin
                  nxt_s.st = ST_RDATA;
                  nxt_s.cnt = 3'h0;
                  nxt_s.sh = rd_byte(s_ff.ptr, s_ff.reg0, s_ff.reg1);
                  nxt_s.oe = ~nxt_s.sh[7];
               end else begin
                  nxt_s.st = ST_IDLE;
               end
            end
         end
         default: ;
      endcase
      if (start) begin
         nxt_s.st = ST_ADDR;
         nxt_s.cnt = 3'h0;
         nxt_s.got = 1'b0;
         nxt_s.oe = 1'b0;
      end else if (stop) begin
         nxt_s.st = ST_IDLE;
         nxt_s.oe = 1'b0;
      end
      // whole-byte store keeps reserved bits as written
      if (wr_en) begin
         if (s_ff.ptr == INLIM_OFS) begin
            nxt_s.reg0 = s_ff.sh;
         end else begin
            nxt_s.reg1 = s_ff.sh;
         end
      end
      // source detection overrides a host write in the same cycle
      if (src_detect_done) begin
         nxt_s.reg0[ILIM_MSB:0] = psel_f ? ILIM_PSEL_HIGH : ILIM_PSEL_LOW;
      end
      if (wdog_expire) begin
         nxt_s.reg0 = (nxt_s.reg0 & ~WD_MASK0) | (INLIM_RST & WD_MASK0);
         nxt_s.reg1 = (nxt_s.reg1 & ~WD_MASK1) | (CTRL0_RST & WD_MASK1);
         nxt_s.host = 1'b0;
      end
      // a write in the expiry cycle still lands in host mode
      if (wr_en) begin
         nxt_s.host = 1'b1;
      end
      if (reg_reset) begin
         nxt_s.reg0 = INLIM_RST;
         nxt_s.reg1 = CTRL0_RST;
         nxt_s.host = 1'b0;
      end
      nxt_s.chg = ~ce_n_f & s_ff.reg1[CHGEN_BIT] & ichg_nonzero
                  & (s_ff.reg0[TSOVR_BIT] | ts_good);
      nxt_s.ntc = s_ff.reg0[TSOVR_BIT] ? 3'h0 : thermistor_fault_code_raw;
   end

   // register the whole state
   always_ff @(posedge clock) begin
      if (!rstn) begin
         s_ff <= '0;
         s_ff.scl_q <= 1'b1;
         s_ff.sda_q <= 1'b1;
         s_ff.reg0 <= INLIM_RST;
         s_ff.reg1 <= CTRL0_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // open-drain data line: only ever pulled low
   assign sda_pin_o = 1'b0;
   assign sda_pin_oe = s_ff.oe;
   assign high_impedance_enable = s_ff.reg0[HIZ_BIT];
   assign temp_sense_override = s_ff.reg0[TSOVR_BIT];
   assign remote_sense_disable = s_ff.reg0[RSNS_BIT];
   assign input_current_limit = s_ff.reg0[ILIM_MSB:0];
   assign input_limit_ma = ilim_ma(s_ff.reg0[ILIM_MSB:0]);
   assign pulse_freq_mode_disable = s_ff.reg1[PFM_BIT];
   assign watchdog_restart = s_ff.reg1[KICK_BIT];
   assign charge_enable_bit = s_ff.reg1[CHGEN_BIT];
   assign system_min_voltage = s_ff.reg1[SYSMIN_MSB:SYSMIN_LSB];
   assign system_min_voltage_mv = sysmin_mv(s_ff.reg1[SYSMIN_MSB:SYSMIN_LSB]);
   assign thermistor_fault_code = s_ff.ntc;
   assign charge_active = s_ff.chg;
   assign host_mode = s_ff.host;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_reset_input: assert property ($rose(rstn) |-> s_ff.reg0 == INLIM_RST)
      else $error("input register not at reset value");
   a_reset_ctrl: assert property ($rose(rstn) |-> s_ff.reg1 == CTRL0_RST)
      else $error("control register not at reset value");
   a_kick_clear: assert property (watchdog_restart && !wr_en |=> !watchdog_restart)
      else $error("watchdog kick did not clear itself");
   a_wdog_defaults: assert property (wdog_expire && !reg_reset |=>
      !high_impedance_enable && charge_enable_bit && !watchdog_restart)
      else $error("watchdog expiry left fields off default");
   a_wdog_keeps: assert property (wdog_expire && !reg_reset && !wr_en
      && !src_detect_done |=> $stable(s_ff.reg0[6:0]) && $stable(system_min_voltage))
      else $error("watchdog expiry touched a register-reset-only field");
   a_src_detect: assert property (src_detect_done && !reg_reset && !wdog_expire
      |=> input_current_limit == ($past(psel_f) ? ILIM_PSEL_HIGH : ILIM_PSEL_LOW))
      else $error("source detection loaded wrong limit");
   a_charge_gate: assert property (charge_active |->
      $past(!ce_n_f && charge_enable_bit && ichg_nonzero))
      else $error("charging without all enables");
   a_ntc_override: assert property (temp_sense_override |=> thermistor_fault_code == 3'h0)
      else $error("thermistor fault shown while overridden");
   a_write_host: assert property (wr_en && !reg_reset |=> host_mode)
      else $error("write did not enter host mode");
   a_addr_match: assert property ($past(s_ff.st) == ST_ADDR && s_ff.st == ST_ACK
      |-> $past(s_ff.sh[7:1]) == I2C_TARGET_ADDR ##1 sda_pin_oe)
      else $error("acknowledged a foreign address");

   c_write: cover property (wr_en ##1 host_mode);
   c_read: cover property (s_ff.st == ST_RDATA ##[1:1000] s_ff.st == ST_RACK);
   c_detect: cover property (src_detect_done && psel_f);
   c_charge: cover property ($rose(charge_active));

endmodule : cic_regs

/* test/cic_host_model.sv */
/*
 * cic_host_model: bit-banged two-wire bus host that drives the register block.
 * Assumes a pulled-up data line resolved by the bench and a low time of 12 clocks.
 */
`timescale 1ns/1ps
module cic_host_model #(
   parameter int Q = 6
) (
   input wire logic clock,
   input wire logic sda_line,
   output logic scl,
   output logic sda_drv
);
   // idle bus: both lines high, serial clock stands still between frames
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // every change lands one ns after a rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   // one bit: data set while clock low, sampled mid-high
   task automatic bit_io(input logic b, output logic s);
      tick(Q);
      sda_drv = b;
      tick(Q);
      scl = 1'b1;
      tick(Q);
      s = sda_line;
      tick(Q);
      scl = 1'b0;
   endtask : bit_io

   // start or repeated start
   task automatic start();
      tick(Q);
      sda_drv = 1'b1;
      tick(Q);
      scl = 1'b1;
      tick(Q);
      sda_drv = 1'b0;
      tick(Q);
      scl = 1'b0;
   endtask : start

   task automatic stop();
      tick(Q);
      sda_drv = 1'b0;
      tick(Q);
      scl = 1'b1;
      tick(Q);
      sda_drv = 1'b1;
      tick(Q);
   endtask : stop

   // msb first, ninth clock returns the target's acknowledge
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : put_byte

   // host releases the line for data, then acks unless this is the last byte
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, s);
   endtask : get_byte
endmodule : cic_host_model

/* test/charger_input_and_control_regs_test.sv */
/*
 * charger_input_and_control_regs_test: self-checking bench for cic_regs.
 * Assumes the host model is the only other driver of the pulled-up data line.
 */
`timescale 1ns/1ps
module charger_input_and_control_regs_test;
   logic clock = 1'b0;
   logic rstn, scl_pin, host_sda, sda_pin_i, sda_pin_o, sda_pin_oe, ce_n_pin, psel_pin;
   logic reg_reset, wdog_expire, src_detect_done, ts_good, ichg_nonzero, ack;
   logic [2:0] thermistor_fault_code_raw, system_min_voltage, thermistor_fault_code;
   logic high_impedance_enable, temp_sense_override, remote_sense_disable;
   logic pulse_freq_mode_disable, watchdog_restart, charge_enable_bit, charge_active, host_mode;
   logic [4:0] input_current_limit;
   logic [11:0] input_limit_ma, system_min_voltage_mv;
   logic [15:0] q;
   logic [11:0] mv_tab [0:7] = '{12'ha28, 12'haf0, 12'hbb8, 12'hc80,
                                 12'hd48, 12'hdac, 12'he10, 12'he74};
   int error_cnt = 0;
   int tests_run = 0;
   int kick_cnt = 0;

   always #12.5 clock = ~clock;
   // open drain with pull-up: low when either party pulls
   assign sda_pin_i = host_sda & ~sda_pin_oe;
   // counts cycles of the restart pulse
   always @(posedge clock) begin
      if (watchdog_restart === 1'b1) kick_cnt <= kick_cnt + 1;
   end

   cic_regs dut (.clock(clock), .rstn(rstn), .scl_pin(scl_pin), .sda_pin_i(sda_pin_i),
      .sda_pin_o(sda_pin_o), .sda_pin_oe(sda_pin_oe), .ce_n_pin(ce_n_pin),
      .psel_pin(psel_pin), .reg_reset(reg_reset), .wdog_expire(wdog_expire),
      .src_detect_done(src_detect_done), .ts_good(ts_good), .thermistor_fault_code_raw(thermistor_fault_code_raw),
      .ichg_nonzero(ichg_nonzero), .high_impedance_enable(high_impedance_enable),
      .temp_sense_override(temp_sense_override), .remote_sense_disable(remote_sense_disable),
      .input_current_limit(input_current_limit), .input_limit_ma(input_limit_ma),
      .pulse_freq_mode_disable(pulse_freq_mode_disable), .watchdog_restart(watchdog_restart),
      .charge_enable_bit(charge_enable_bit), .system_min_voltage(system_min_voltage),
      .system_min_voltage_mv(system_min_voltage_mv), .thermistor_fault_code(thermistor_fault_code),
      .charge_active(charge_active), .host_mode(host_mode));

   cic_host_model host (.clock(clock), .sda_line(sda_pin_i), .scl(scl_pin), .sda_drv(host_sda));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic stop_test();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   // write n bytes from d, first byte in the top half
   task automatic reg_wr(input logic [7:0] ofs, input logic [15:0] d, input int n);
      host.start();
      host.put_byte(8'hd4, ack);
      check("addr ack", ack, 1'b1);
      host.put_byte(ofs, ack);
      check("offset ack", ack, 1'b1);
      for (int i = 0; i < n; i++) begin
         host.put_byte(d[15-8*i -: 8], ack);
         check("data ack", ack, 1'b1);
      end
      host.stop();
      host.tick(4);
   endtask : reg_wr

   // set pointer, repeated start, read n bytes, nack on the last
   task automatic reg_rd(input logic [7:0] ofs, input int n, output logic [15:0] r);
      logic [7:0] b;
      r = 16'h0000;
      host.start();
      host.put_byte(8'hd4, ack);
      host.put_byte(ofs, ack);
      host.start();
      host.put_byte(8'hd5, ack);
      check("read ack", ack, 1'b1);
      for (int i = 0; i < n; i++) begin
         host.get_byte(i == n - 1, b);
         r = {r[7:0], b};
      end
      host.stop();
      host.tick(4);
   endtask : reg_rd

   // side inputs are single-cycle events on the core clock
   task automatic pulse(input int which);
      if (which == 0) reg_reset = 1'b1;
      if (which == 1) wdog_expire = 1'b1;
      if (which == 2) src_detect_done = 1'b1;
      host.tick(1);
      reg_reset = 1'b0;
      wdog_expire = 1'b0;
      src_detect_done = 1'b0;
      host.tick(2);
   endtask : pulse

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rstn = 1'b0;
      ce_n_pin = 1'b0;
      psel_pin = 1'b0;
      {reg_reset, wdog_expire, src_detect_done, ts_good} = 4'h0;
      thermistor_fault_code_raw = 3'h5;
      ichg_nonzero = 1'b1;
      host.tick(12);
      rstn = 1'b1;
      host.tick(6);
      check("host mode", host_mode, 1'b0);
      check("fault code", thermistor_fault_code, 3'h5);
      reg_rd(8'h00, 2, q);
      check("reset regs", q, 16'h171a);
      check("tsense ovr", temp_sense_override, 1'b0);
      check("chg bit", charge_enable_bit, 1'b1);
      check("sysmin code", system_min_voltage, 3'h5);
      check("sda out", sda_pin_o, 1'b0);
      check("limit ma", input_limit_ma, 12'h960);
      check("sysmin mv", system_min_voltage_mv, 12'hdac);
      // multi-write: every field set away from default, kick included
      reg_wr(8'h00, 16'he5e1, 2);
      check("kick pulses", kick_cnt, 16'h0001);
      check("host mode", host_mode, 1'b1);
      reg_rd(8'h00, 2, q);
      check("written regs", q, 16'he5a1);
      check("hiz", high_impedance_enable, 1'b1);
      check("tsense ovr", temp_sense_override, 1'b1);
      check("chg bit", charge_enable_bit, 1'b0);
      check("sysmin code", system_min_voltage, 3'h0);
      check("fault masked", thermistor_fault_code, 3'h0);
      check("remote off", remote_sense_disable, 1'b1);
      check("limit ma", input_limit_ma, 12'h258);
      check("pfm off", pulse_freq_mode_disable, 1'b1);
      check("charge off", charge_active, 1'b0);
      // every system minimum code, charge enabled
      for (int i = 0; i < 8; i++) begin
         reg_wr(8'h01, {8'h10 | {4'h0, i[2:0], 1'h0}, 8'h00}, 1);
         check("sysmin mv", system_min_voltage_mv, mv_tab[i]);
         check("sysmin code", system_min_voltage, i[2:0]);
         check("charge on", charge_active, 1'b1);
      end
      ichg_nonzero = 1'b0;
      host.tick(3);
      check("no current", charge_active, 1'b0);
      ichg_nonzero = 1'b1;
      ce_n_pin = 1'b1;
      host.tick(8);
      check("chip off", charge_active, 1'b0);
      // host clears bit 5 to turn remote sense back on
      reg_wr(8'h00, 16'hc500, 1);
      check("remote on", remote_sense_disable, 1'b0);
      reg_wr(8'h01, 16'ha600, 1);
      pulse(1);
      reg_rd(8'h00, 2, q);
      check("after expiry", q, 16'h45b6);
      // source detection loads the limit, then the host may rewrite it
      psel_pin = 1'b1;
      host.tick(8);
      pulse(2);
      check("limit ma", input_limit_ma, 12'h1f4);
      psel_pin = 1'b0;
      host.tick(8);
      pulse(2);
      check("limit code", input_current_limit, 5'h17);
      reg_wr(8'h00, 16'h1f00, 1);
      check("limit ma", input_limit_ma, 12'hc80);
      // override now clear: the thermistor condition and raw fault count again
      ce_n_pin = 1'b0;
      thermistor_fault_code_raw = 3'h2;
      host.tick(8);
      check("ts gate", charge_active, 1'b0);
      check("fault code", thermistor_fault_code, 3'h2);
      ts_good = 1'b1;
      host.tick(3);
      check("ts good", charge_active, 1'b1);
      // refusals: foreign address, offset past the end, read past the end
      host.start();
      host.put_byte(8'hd6, ack);
      host.stop();
      check("foreign nack", ack, 1'b0);
      host.start();
      host.put_byte(8'hd4, ack);
      host.put_byte(8'h02, ack);
      host.stop();
      check("offset nack", ack, 1'b0);
      reg_rd(8'h01, 2, q);
      check("read past end", q, 16'hb6ff);
      pulse(0);
      check("host mode", host_mode, 1'b0);
      reg_rd(8'h00, 2, q);
      check("reg reset", q, 16'h171a);
      check("kick pulses", kick_cnt, 16'h0001);
      stop_test();
   end

   // whole run is about 15k clocks; this allows five times that
   initial begin
      #2000000;
      error_cnt++;
      stop_test();
   end
endmodule : charger_input_and_control_regs_test
